// File: nvs_consts.svh
// Purpose: constants of the nvm unlock and sector sequencer
// Assumes: 100 MHz system clock, 32-bit classic wishbone
// Notes:   offsets are byte addresses, one aligned word each
`ifndef NVS_CONSTS_SVH
`define NVS_CONSTS_SVH

// register byte offsets
`define NVS_OFS_CTRL 8'h00
`define NVS_OFS_LAUNCH 8'h04
`define NVS_OFS_KEY 8'h08
`define NVS_OFS_ADDR 8'h0C
`define NVS_OFS_DATA 8'h10
`define NVS_OFS_PROT 8'h14
`define NVS_OFS_STAT 8'h18

// memory_control_reg fields
`define NVS_CTL_EN 0
`define NVS_CTL_ERR 1
`define NVS_CTL_DONE 2
`define NVS_CTL_IE 3

// operation_launch_reg fields, one-hot
`define NVS_LB_WORD 0
`define NVS_LB_SECW 1
`define NVS_LB_SECE 2
`define NVS_LB_SECR 3

// key pairs
`define NVS_KEY_WORD1 8'h55
`define NVS_KEY_WORD2 8'hAA
`define NVS_KEY_SECW1 8'hDD
`define NVS_KEY_SECW2 8'h22
`define NVS_KEY_SECE1 8'hCC
`define NVS_KEY_SECE2 8'h33
`define NVS_KEY_SECR1 8'hBB
`define NVS_KEY_SECR2 8'h44

// address map, 22-bit byte addresses
`define NVS_PFM_LAST 22'h00FFFF
`define NVS_CFG_FIRST 22'h300000
`define NVS_CFG_LAST 22'h30000B
`define NVS_DFM_FIRST 22'h310000
`define NVS_DFM_LAST 22'h3103FF
`define NVS_SECTOR_MASK 22'h3FFF00

// reset values
`define NVS_PROT_RST 22'h000000

// timing
`define NVS_CLK_MHZ 100
`define NVS_ERASE_TIME_US 10000
`define NVS_SECW_TIME_US 10000
`define NVS_WORD_TIME_US 50
`define NVS_READ_TIME_NS 1000
`define NVS_ERASE_CYC (`NVS_ERASE_TIME_US * `NVS_CLK_MHZ)
`define NVS_SECW_CYC (`NVS_SECW_TIME_US * `NVS_CLK_MHZ)
`define NVS_WORD_CYC (`NVS_WORD_TIME_US * `NVS_CLK_MHZ)
`define NVS_READ_CYC ((`NVS_READ_TIME_NS * `NVS_CLK_MHZ) / 1000)
`define NVS_KEY_GAP_CYC 5'd8

`endif

// File: nvs_pkg.sv
// Purpose: types of the nvm unlock and sector sequencer
// Assumes: nothing beyond the constants header
// Notes:   state codes are one-hot
package nvs_pkg;
  typedef enum logic [2:0] {
    NVS_KEY_IDLE = 3'b001,
    NVS_KEY_HALF = 3'b010,
    NVS_KEY_ARMED = 3'b100
  } nvs_key_e;

  typedef enum logic [1:0] {
    NVS_SEQ_IDLE = 2'b01,
    NVS_SEQ_BUSY = 2'b10
  } nvs_seq_e;

  typedef enum logic [1:0] {
    NVS_MEM_PFM = 2'b00,
    NVS_MEM_CFG = 2'b01,
    NVS_MEM_DFM = 2'b10,
    NVS_MEM_BAD = 2'b11
  } nvs_mem_e;
endpackage : nvs_pkg

// File: nvs_nvm_sequencer.sv
// Purpose: unlock key checker and long-write sequencer for on-chip nvm
// Assumes: classic wishbone slave, one answer per request, 100 MHz
// Notes:   holding registers and table logic live outside this block
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "nvs_consts.svh"

////////////////////////////////////////////////////////////////////////
module nvs_nvm_sequencer
  import nvs_pkg::*;
#(
  parameter int ERASE_CYC = `NVS_ERASE_CYC,
  parameter int SECW_CYC = `NVS_SECW_CYC,
  parameter int WORD_CYC = `NVS_WORD_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpuDisturb,
  input wire logic abortEvent,
  output logic cpuStall,
  output logic [3:0] memOpLaunch,
  output logic [21:0] memOpAddr,
  output logic [15:0] memOpData,
  output logic nvmIrq
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] keyFirstOp(input logic [7:0] k);
    logic [3:0] op;
    op = 4'h0;
    if (k == `NVS_KEY_WORD1) op[`NVS_LB_WORD] = 1'b1;
    else if (k == `NVS_KEY_SECW1) op[`NVS_LB_SECW] = 1'b1;
    else if (k == `NVS_KEY_SECE1) op[`NVS_LB_SECE] = 1'b1;
    else if (k == `NVS_KEY_SECR1) op[`NVS_LB_SECR] = 1'b1;
    return op;
  endfunction : keyFirstOp

  function automatic logic [7:0] keySecond(input logic [3:0] op);
    logic [7:0] k;
    k = 8'h00;
    case (op)
      4'h1: k = `NVS_KEY_WORD2;
      4'h2: k = `NVS_KEY_SECW2;
      4'h4: k = `NVS_KEY_SECE2;
      4'h8: k = `NVS_KEY_SECR2;
      default: k = 8'h00;
    endcase
    return k;
  endfunction : keySecond

  function automatic nvs_mem_e memKind(input logic [21:0] a);
    nvs_mem_e m;
    m = NVS_MEM_BAD;
    if (a <= `NVS_PFM_LAST) m = NVS_MEM_PFM;
    else if (a >= `NVS_CFG_FIRST && a <= `NVS_CFG_LAST) m = NVS_MEM_CFG;
    else if (a >= `NVS_DFM_FIRST && a <= `NVS_DFM_LAST) m = NVS_MEM_DFM;
    return m;
  endfunction : memKind

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : laneMerge

  ////////////////////////////////////////////////////////////////////
  // register state

  logic accessEnable_reg;
  logic errFlag_reg;
  logic doneFlag_reg;
  logic doneIe_reg;
  logic [21:0] targetAddr_reg;
  logic [15:0] wordData_reg;
  logic [21:0] protLimit_reg;
  nvs_key_e keyState_reg;
  logic [3:0] keyOp_reg;
  logic [4:0] gapCnt_reg;
  nvs_seq_e seqState_reg;
  logic [19:0] opCnt_reg;
  nvs_mem_e opKind_reg;

  logic req;
  logic wrStb;
  logic keyWr;
  logic launchWr;
  logic ctlWr;
  logic [3:0] launchBits;
  logic armedHit;
  logic opStart;
  logic startOk;
  logic startErr;
  logic opEnd;
  logic opAbort;
  logic gapOver;
  nvs_mem_e startKind;
  logic protHit;
  logic [31:0] readData;
  logic [19:0] startCnt;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrStb = req && wb_we_i;
  assign keyWr = wrStb && wb_adr_i == `NVS_OFS_KEY && wb_sel_i[0];
  assign launchWr = wrStb && wb_adr_i == `NVS_OFS_LAUNCH && wb_sel_i[0];
  assign ctlWr = wrStb && wb_adr_i == `NVS_OFS_CTRL && wb_sel_i[0];
  assign launchBits = wb_dat_i[3:0];
  assign gapOver = keyState_reg != NVS_KEY_IDLE && gapCnt_reg >= `NVS_KEY_GAP_CYC;

  // launch counts only as the step right after a valid key pair
  assign armedHit = launchWr && keyState_reg == NVS_KEY_ARMED && !gapOver && !cpuDisturb
                    && launchBits == keyOp_reg;
  assign opStart = armedHit && seqState_reg == NVS_SEQ_IDLE;
  assign startKind = memKind(targetAddr_reg);
  assign protHit = startKind == NVS_MEM_PFM && targetAddr_reg < protLimit_reg;

  always_comb begin
    startOk = 1'b0;
    if (opStart) begin
      if (keyOp_reg[`NVS_LB_WORD]) begin
        startOk = accessEnable_reg && startKind != NVS_MEM_BAD && !protHit;
      end else if (keyOp_reg[`NVS_LB_SECR]) begin
        startOk = startKind == NVS_MEM_PFM;
      end else begin
        // sector ops touch program flash only, never config or data flash
        startOk = accessEnable_reg && startKind == NVS_MEM_PFM && !protHit;
      end
    end
  end
  assign startErr = opStart && !startOk;

  always_comb begin
    startCnt = 20'(WORD_CYC - 1);
    if (keyOp_reg[`NVS_LB_SECE]) startCnt = 20'(ERASE_CYC - 1);
    else if (keyOp_reg[`NVS_LB_SECW]) startCnt = 20'(SECW_CYC - 1);
    else if (keyOp_reg[`NVS_LB_SECR]) startCnt = 20'(`NVS_READ_CYC - 1);
  end

  assign opAbort = seqState_reg == NVS_SEQ_BUSY && abortEvent;
  assign opEnd = seqState_reg == NVS_SEQ_BUSY && !abortEvent && opCnt_reg == 20'h00000;

  ////////////////////////////////////////////////////////////////////
  // unlock key checker

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      keyState_reg <= NVS_KEY_IDLE;
      keyOp_reg <= 4'h0;
      gapCnt_reg <= 5'd0;
    end else if (gapOver || cpuDisturb) begin
      // a late step means the cpu was held off; refuse the sequence
      keyState_reg <= NVS_KEY_IDLE;
      keyOp_reg <= 4'h0;
      gapCnt_reg <= 5'd0;
    end else if (keyWr) begin
      gapCnt_reg <= 5'd0;
      case (keyState_reg)
        NVS_KEY_IDLE: begin
          keyOp_reg <= keyFirstOp(wb_dat_i[7:0]);
          keyState_reg <= (keyFirstOp(wb_dat_i[7:0]) != 4'h0) ? NVS_KEY_HALF : NVS_KEY_IDLE;
        end
        NVS_KEY_HALF: begin
          keyState_reg <= (wb_dat_i[7:0] == keySecond(keyOp_reg)) ? NVS_KEY_ARMED : NVS_KEY_IDLE;
        end
        default: begin
          keyState_reg <= NVS_KEY_IDLE;
          keyOp_reg <= 4'h0;
        end
      endcase
    end else if (wrStb) begin
      // any other write, the launch included, ends the attempt
      keyState_reg <= NVS_KEY_IDLE;
      keyOp_reg <= 4'h0;
      gapCnt_reg <= 5'd0;
    end else if (keyState_reg != NVS_KEY_IDLE) begin
      gapCnt_reg <= gapCnt_reg + 5'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // operation sequencer

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seqState_reg <= NVS_SEQ_IDLE;
      opCnt_reg <= 20'h00000;
      opKind_reg <= NVS_MEM_PFM;
      memOpLaunch <= 4'h0;
      memOpAddr <= 22'h000000;
      memOpData <= 16'h0000;
      cpuStall <= 1'b0;
    end else begin
      case (seqState_reg)
        NVS_SEQ_IDLE: begin
          if (startOk) begin
            seqState_reg <= NVS_SEQ_BUSY;
            opCnt_reg <= startCnt;
            opKind_reg <= startKind;
            memOpLaunch <= keyOp_reg;
            memOpData <= wordData_reg;
            memOpAddr <= keyOp_reg[`NVS_LB_WORD] ? targetAddr_reg
                                                 : (targetAddr_reg & `NVS_SECTOR_MASK);
            cpuStall <= startKind != NVS_MEM_DFM;
          end
        end
        NVS_SEQ_BUSY: begin
          if (opAbort || opEnd) begin
            seqState_reg <= NVS_SEQ_IDLE;
            memOpLaunch <= 4'h0;
            cpuStall <= 1'b0;
          end else begin
            opCnt_reg <= opCnt_reg - 20'h00001;
          end
        end
        default: begin
          seqState_reg <= NVS_SEQ_IDLE;
          memOpLaunch <= 4'h0;
          cpuStall <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software registers

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      accessEnable_reg <= 1'b0;
      doneIe_reg <= 1'b0;
      errFlag_reg <= 1'b0;
      doneFlag_reg <= 1'b0;
    end else begin
      if (ctlWr) begin
        accessEnable_reg <= wb_dat_i[`NVS_CTL_EN];
        doneIe_reg <= wb_dat_i[`NVS_CTL_IE];
      end
      if (startErr || opAbort) errFlag_reg <= 1'b1;
      else if (ctlWr && !wb_dat_i[`NVS_CTL_ERR]) errFlag_reg <= 1'b0;
      if (opEnd) doneFlag_reg <= 1'b1;
      else if (ctlWr && !wb_dat_i[`NVS_CTL_DONE]) doneFlag_reg <= 1'b0;
    end
  end

  // address and data freeze while busy so the array sees stable values
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      targetAddr_reg <= 22'h000000;
      wordData_reg <= 16'h0000;
      protLimit_reg <= `NVS_PROT_RST;
    end else if (wrStb && seqState_reg == NVS_SEQ_IDLE) begin
      if (wb_adr_i == `NVS_OFS_ADDR) begin
        targetAddr_reg <= 22'(laneMerge({10'h000, targetAddr_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `NVS_OFS_DATA) begin
        wordData_reg <= 16'(laneMerge({16'h0000, wordData_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `NVS_OFS_PROT) begin
        protLimit_reg <= 22'(laneMerge({10'h000, protLimit_reg}, wb_dat_i, wb_sel_i));
      end
    end
  end

  always_comb begin
    readData = 32'h00000000;
    if (wb_adr_i == `NVS_OFS_CTRL) begin
      readData = {28'h0000000, doneIe_reg, doneFlag_reg, errFlag_reg, accessEnable_reg};
    end else if (wb_adr_i == `NVS_OFS_LAUNCH) begin
      readData = {28'h0000000, memOpLaunch};
    end else if (wb_adr_i == `NVS_OFS_KEY) begin
      readData = 32'h00000000;
    end else if (wb_adr_i == `NVS_OFS_ADDR) begin
      readData = {10'h000, targetAddr_reg};
    end else if (wb_adr_i == `NVS_OFS_DATA) begin
      readData = {16'h0000, wordData_reg};
    end else if (wb_adr_i == `NVS_OFS_PROT) begin
      readData = {10'h000, protLimit_reg};
    end else if (wb_adr_i == `NVS_OFS_STAT) begin
      readData = {25'h0000000, seqState_reg, keyState_reg, opKind_reg};
    end
  end

  // every request is answered one cycle later, unmapped ones read zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) wb_dat_o <= readData;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      nvmIrq <= 1'b0;
    end else begin
      nvmIrq <= doneFlag_reg && doneIe_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_LAUNCH_NEEDS_ARM: assert property (
    $rose(|memOpLaunch) |-> $past(keyState_reg == NVS_KEY_ARMED && launchWr)
  ) else $error("operation started without a complete key sequence");

  AST_ERASE_KEYS: assert property (
    $rose(memOpLaunch[`NVS_LB_SECE]) |-> $past(keyOp_reg == 4'h4)
  ) else $error("erase started under a foreign key pair");

  AST_ERASE_MASKED: assert property (
    memOpLaunch[`NVS_LB_SECE] |-> memOpAddr[7:0] == 8'h00
  ) else $error("erase address not sector aligned");

  AST_ERASE_NEEDS_EN: assert property (
    opStart && keyOp_reg[`NVS_LB_SECE] && !accessEnable_reg |=> errFlag_reg && memOpLaunch == 4'h0
  ) else $error("erase accepted without access enable");

  AST_PROT_ERR: assert property (
    opStart && !keyOp_reg[`NVS_LB_SECR] && protHit |=> errFlag_reg && seqState_reg == NVS_SEQ_IDLE
  ) else $error("protected target not refused");

  AST_BAD_ADDR_ERR: assert property (
    opStart && startKind == NVS_MEM_BAD |=> errFlag_reg && memOpLaunch == 4'h0
  ) else $error("invalid target not refused");

  AST_STALL: assert property (
    (|memOpLaunch) && opKind_reg != NVS_MEM_DFM |-> cpuStall
  ) else $error("program flash operation without stall");

  AST_NO_DFM_STALL: assert property (
    (|memOpLaunch) && opKind_reg == NVS_MEM_DFM |-> !cpuStall
  ) else $error("data flash operation stalled the cpu");

  AST_DONE_FLAG: assert property (
    opEnd |=> doneFlag_reg && memOpLaunch == 4'h0 && !cpuStall ##1 nvmIrq == doneIe_reg
  ) else $error("completion not flagged");

  AST_ABORT_ERR: assert property (
    opAbort |=> errFlag_reg && !doneFlag_reg == !$past(doneFlag_reg) && memOpLaunch == 4'h0
  ) else $error("aborted operation not flagged");

  AST_GAP_CANCEL: assert property (
    gapOver |=> keyState_reg == NVS_KEY_IDLE
  ) else $error("late step kept the sequence alive");

  AST_EN_KEPT: assert property (
    seqState_reg == NVS_SEQ_BUSY && !ctlWr |=> $stable(accessEnable_reg)
  ) else $error("operation changed access enable");

  AST_WB_ACK: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("bus answer not one cycle");

  COV_ERASE_DONE: cover property (opEnd && memOpLaunch[`NVS_LB_SECE]);
  COV_WORD_DFM: cover property ($rose(memOpLaunch[`NVS_LB_WORD]) && opKind_reg == NVS_MEM_DFM);
  COV_PROT_REFUSE: cover property (startErr && protHit);
  COV_ABORT: cover property (opAbort);

endmodule : nvs_nvm_sequencer
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for the nvm unlock and sector sequencer
// Assumes: short erase, sector write and word counts set by parameter, read count left at its default, lfsr stimulus seeded at 77349
// Notes:   drives the wishbone port and the event inputs directly
`timescale 1ns/1ps
`default_nettype none
`include "nvs_consts.svh"

module tb_top import nvs_pkg::*;;
  localparam int OP_CYC = 20;
  localparam int RD_CYC = 100;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR;
  logic wbAck, cpuDisturb = 1'b0, abortEvent = 1'b0, cpuStall, nvmIrq;
  logic [3:0] memOpLaunch;
  logic [21:0] memOpAddr;
  logic [15:0] memOpData;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] lfsrState = 32'd77349;

  always #5 sys_clk = ~sys_clk;

  nvs_nvm_sequencer #(.ERASE_CYC(OP_CYC), .SECW_CYC(OP_CYC), .WORD_CYC(OP_CYC)) nvs_nvm_sequencer_i (
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .cpuDisturb(cpuDisturb), .abortEvent(abortEvent), .cpuStall(cpuStall),
    .memOpLaunch(memOpLaunch), .memOpAddr(memOpAddr), .memOpData(memOpData), .nvmIrq(nvmIrq));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // sector ops drop the offset within the sector, word ops keep it
  function automatic logic [21:0] exp_addr(input int op, input logic [21:0] a);
    return (op == 0) ? a : (a & `NVS_SECTOR_MASK);
  endfunction : exp_addr

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  ////////////////////////////////////////////////////////////////////////
  // one classic cycle; the master waits for ack up to 50 cycles, then counts a mismatch
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDatW <= d; wbSel <= 4'hF;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatR;
    if (n >= 50) cmp(32'h0, 32'h1, "bus answer");
    wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
  endtask : wb_cycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb_cycle(1'b0, a, 32'h0, q);
  endtask : rd

  // callers keep cpuDisturb low across the steps, as masked interrupts would
  task automatic unlock(input logic [7:0] k1, input logic [7:0] k2, input logic [3:0] lb);
    wr(`NVS_OFS_KEY, {24'h0, k1});
    wr(`NVS_OFS_KEY, {24'h0, k2});
    wr(`NVS_OFS_LAUNCH, {28'h0, lb});
    #1;
  endtask : unlock

  // counts edges after the launch write until the operation ends
  task automatic wait_end(output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end while (memOpLaunch !== 4'h0 && cnt < 500);
  endtask : wait_end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] keyA [4] = '{`NVS_KEY_WORD1, `NVS_KEY_SECW1, `NVS_KEY_SECE1, `NVS_KEY_SECR1};
  logic [7:0] keyB [4] = '{`NVS_KEY_WORD2, `NVS_KEY_SECW2, `NVS_KEY_SECE2, `NVS_KEY_SECR2};

  initial begin
    logic [31:0] q;
    logic [21:0] a;
    int cnt;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    cmp({26'h0, cpuStall, nvmIrq, memOpLaunch}, 32'h0, "reset outputs");
    rd(`NVS_OFS_CTRL, q); cmp(q, 32'h0, "ctrl reset");
    rd(`NVS_OFS_PROT, q); cmp(q, {10'h0, `NVS_PROT_RST}, "prot reset");
    rd(8'hFC, q); cmp(q, 32'h0, "unmapped read");
    wr(`NVS_OFS_KEY, 32'hCC); rd(`NVS_OFS_KEY, q); cmp(q, 32'h0, "key reads zero");
    $display("test reset done");
    // every operation, random program-flash target
    wr(`NVS_OFS_CTRL, 32'h9);
    for (int i = 0; i < 4; i++) begin
      lfsrState = lfsr_next(lfsrState);
      a = lfsrState[21:0] & `NVS_PFM_LAST;
      wr(`NVS_OFS_ADDR, {10'h0, a});
      wr(`NVS_OFS_DATA, {16'h0, lfsrState[31:16]});
      unlock(keyA[i], keyB[i], 4'(1 << i));
      cmp({28'h0, memOpLaunch}, 32'(1 << i), "launched op");
      cmp({31'h0, cpuStall}, 32'h1, "stall");
      cmp({10'h0, memOpAddr}, {10'h0, exp_addr(i, a)}, "target");
      if (i == 0) cmp({16'h0, memOpData}, {16'h0, lfsrState[31:16]}, "word data");
      wait_end(cnt);
      cmp(cnt, (i == 3) ? RD_CYC - 1 : OP_CYC - 1, "duration");
      cmp({31'h0, cpuStall}, 32'h0, "stall released");
      rd(`NVS_OFS_CTRL, q);
      cmp({28'h0, q[3:0]}, 32'hD, "done flag, enable kept");
      cmp({31'h0, nvmIrq}, 32'h1, "done irq");
      wr(`NVS_OFS_CTRL, 32'h9);
      $display("test op %0d done", i);
    end
    // data flash word write runs without stalling
    wr(`NVS_OFS_ADDR, {10'h0, `NVS_DFM_FIRST + 22'h5});
    unlock(`NVS_KEY_WORD1, `NVS_KEY_WORD2, 4'h1);
    cmp({31'h0, cpuStall}, 32'h0, "no stall on data flash");
    cmp({28'h0, memOpLaunch}, 32'h1, "data flash launch");
    rd(`NVS_OFS_LAUNCH, q); cmp(q, 32'h1, "launch readback");
    rd(`NVS_OFS_STAT, q); cmp(q, {25'h0, NVS_SEQ_BUSY, NVS_KEY_IDLE, NVS_MEM_DFM}, "status busy");
    // target must not move under a running operation
    wr(`NVS_OFS_ADDR, 32'h0000_0100);
    wait_end(cnt);
    rd(`NVS_OFS_ADDR, q); cmp(q, {10'h0, `NVS_DFM_FIRST + 22'h5}, "address frozen while busy");
    wr(`NVS_OFS_CTRL, 32'h1);
    $display("test data flash done");
    // config word write stalls; no interrupt with its enable clear
    wr(`NVS_OFS_ADDR, {10'h0, `NVS_CFG_FIRST});
    unlock(`NVS_KEY_WORD1, `NVS_KEY_WORD2, 4'h1);
    cmp({31'h0, cpuStall}, 32'h1, "config stall");
    wait_end(cnt);
    cmp(cnt, OP_CYC - 1, "config duration");
    rd(`NVS_OFS_CTRL, q); cmp(q, 32'h5, "done without irq enable");
    cmp({31'h0, nvmIrq}, 32'h0, "irq masked");
    wr(`NVS_OFS_CTRL, 32'h1);
    $display("test config word done");
    // broken sequences: wrong key, foreign key pair, disturbed, late step
    wr(`NVS_OFS_ADDR, 32'h0000_4000);
    unlock(`NVS_KEY_SECE1, 8'h34, 4'h4); cmp({28'h0, memOpLaunch}, 32'h0, "wrong key");
    unlock(`NVS_KEY_WORD1, `NVS_KEY_WORD2, 4'h4); cmp({28'h0, memOpLaunch}, 32'h0, "bit mismatch");
    wr(`NVS_OFS_KEY, 32'hCC);
    @(posedge sys_clk); cpuDisturb <= 1'b1;
    @(posedge sys_clk); cpuDisturb <= 1'b0;
    wr(`NVS_OFS_KEY, 32'h33); wr(`NVS_OFS_LAUNCH, 32'h4); #1;
    cmp({28'h0, memOpLaunch}, 32'h0, "disturbed");
    wr(`NVS_OFS_KEY, 32'hCC); repeat (10) @(posedge sys_clk);
    wr(`NVS_OFS_KEY, 32'h33); wr(`NVS_OFS_LAUNCH, 32'h4); #1;
    cmp({28'h0, memOpLaunch}, 32'h0, "late step");
    wr(`NVS_OFS_CTRL, 32'h0);
    unlock(`NVS_KEY_SECE1, `NVS_KEY_SECE2, 4'h4);
    cmp({28'h0, memOpLaunch}, 32'h0, "access disabled");
    $display("test broken sequences done");
    // protected, invalid, aborted
    wr(`NVS_OFS_CTRL, 32'h1); wr(`NVS_OFS_PROT, 32'h0000_8000);
    unlock(`NVS_KEY_SECE1, `NVS_KEY_SECE2, 4'h4);
    cmp({28'h0, memOpLaunch}, 32'h0, "protected");
    @(posedge sys_clk); #1; rd(`NVS_OFS_CTRL, q); cmp({31'h0, q[1]}, 32'h1, "protect error");
    wr(`NVS_OFS_ADDR, 32'h0000_7000); unlock(`NVS_KEY_SECW1, `NVS_KEY_SECW2, 4'h2);
    cmp({28'h0, memOpLaunch}, 32'h0, "protected sector write");
    wr(`NVS_OFS_PROT, 32'h0); wr(`NVS_OFS_CTRL, 32'h1);
    wr(`NVS_OFS_ADDR, 32'h0020_0000);
    unlock(`NVS_KEY_SECE1, `NVS_KEY_SECE2, 4'h4);
    cmp({28'h0, memOpLaunch}, 32'h0, "invalid");
    @(posedge sys_clk); #1; rd(`NVS_OFS_CTRL, q); cmp({31'h0, q[1]}, 32'h1, "invalid error");
    wr(`NVS_OFS_CTRL, 32'h1); wr(`NVS_OFS_ADDR, 32'h0000_1234);
    unlock(`NVS_KEY_SECE1, `NVS_KEY_SECE2, 4'h4);
    @(posedge sys_clk); abortEvent <= 1'b1;
    @(posedge sys_clk); abortEvent <= 1'b0;
    wait_end(cnt);
    rd(`NVS_OFS_CTRL, q); cmp({30'h0, q[2:1]}, 32'h1, "abort error, no done");
    $display("test errors done");
    complete_run();
  end

  initial begin
    #(20000 * 10);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
